// >>> verilog/custom_alu_params.svh
// Encoding constants for the custom ALU and immediate branch group
`ifndef CUSTOM_ALU_PARAMS_SVH
`define CUSTOM_ALU_PARAMS_SVH

`define XLEN              32
`define OPC_GEN_ALU       7'h2B
`define OPC_SHIFT_ADDSUB  7'h5B
`define OPC_IMM_BRANCH    7'h0B
`define F3_GEN_ALU        3'h3
`define F3_ADD_SHIFT      3'h2
`define F3_SUB_SHIFT      3'h3
`define F3_BRANCH_EQ      3'h6
`define F3_BRANCH_NE      3'h7
`define F7_ABS            7'h28
`define F7_SLE            7'h29
`define F7_SLEU           7'h2A
`define F7_MIN            7'h2B
`define F7_MINU           7'h2C
`define F7_MAX            7'h2D
`define F7_MAXU           7'h2E
`define F7_EXT_HALF_S     7'h30
`define F7_EXT_HALF_Z     7'h31
`define F7_EXT_BYTE_S     7'h32
`define F7_EXT_BYTE_Z     7'h33
`define F7_CLIP_IMM_S     7'h38
`define F7_CLIP_IMM_U     7'h39
`define F7_CLIP_REG_S     7'h3A
`define F7_CLIP_REG_U     7'h3B
`define F7_REGSHIFT_BASE  4'h8
`define REG_RESET_VALUE   32'h0000_0000
`define PC_STEP           32'h0000_0004

`endif

// >>> verilog/custom_alu_pkg.sv
// Types shared by the custom ALU files
`default_nettype none
package custom_alu_pkg;

  typedef enum {
    OP_NONE,
    OP_ABS,
    OP_SLE_S,
    OP_SLE_U,
    OP_MIN_S,
    OP_MIN_U,
    OP_MAX_S,
    OP_MAX_U,
    OP_EXT_HALF_S,
    OP_EXT_HALF_Z,
    OP_EXT_BYTE_S,
    OP_EXT_BYTE_Z,
    OP_CLIP_IMM_S,
    OP_CLIP_IMM_U,
    OP_CLIP_REG_S,
    OP_CLIP_REG_U,
    OP_ADDSUB_SHIFT,
    OP_BRANCH_EQ,
    OP_BRANCH_NE,
    OP_ILLEGAL
  } alu_op_type;

endpackage
`default_nettype wire

// >>> verilog/shift_round_unit.sv
// Add or subtract, optional rounding term, then right shift
`timescale 1ns/100ps
`default_nettype none
module shift_round_unit
  import custom_alu_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic [WIDTH-1:0] lhs_i,
  input  wire logic [WIDTH-1:0] rhs_i,
  input  wire logic             subtract_i,
  input  wire logic             arith_i,
  input  wire logic             round_i,
  input  wire logic [4:0]       shamt_i,
  output logic      [WIDTH-1:0] result_o
);

  logic [WIDTH-1:0] combined;
  logic [WIDTH-1:0] round_term;
  logic [WIDTH-1:0] biased;

  always_comb begin
    combined   = subtract_i ? WIDTH'(lhs_i - rhs_i) : WIDTH'(lhs_i + rhs_i);
    // Zero shift adds nothing: 2^(n-1) has no meaning at n = 0
    round_term = '0;
    if (round_i && (shamt_i != 5'h0)) begin
      round_term = WIDTH'(1) << (shamt_i - 5'h1);
    end
    biased     = WIDTH'(combined + round_term);
    if (arith_i) begin
      result_o = WIDTH'($signed(biased) >>> shamt_i);
    end else begin
      result_o = biased >> shamt_i;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/custom_alu_exec.sv
// Custom ALU group and compare-with-immediate branch: decode and execute
//
// What this block does
// - Unsigned rounding register-shift add: rd+rs1+round, logical.
// - Signed register-shift subtract: rd-rs1, arithmetic shift.
// - Unsigned register-shift subtract: rd-rs1, logical shift.
// - Rounding register-shift subtracts add 2^(n-1) first.
// - Rounding term is zero when shift is zero.
// - Decode general ALU group: abs, sle, min, max.
// - Decode extensions; bits 24:20 must be zero.
// - Decode immediate and register clip forms.
// - Decode add-then-shift forms by bits 31:30.
// - Decode subtract-then-shift forms likewise.
// - Decode eight register-shift variants in order.
// - Branch on equal to immediate, offset doubled.
// - Branch on not equal to immediate.
// - Compare immediate is sign extended.
// - Decode immediate branches and scattered offset bits.
// - Set-less-or-equal, min, max, signed or unsigned.
// - Sign or zero extend low half or byte.
// - Immediate clip saturates; zero gives -1..0 signed, 0..0 unsigned.
// - Immediate add-shift; shift of one averages.
`timescale 1ns/100ps
`default_nettype none
`include "custom_alu_params.svh"
module custom_alu_exec
  import custom_alu_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        custom_extension_enable_i,
  input  wire logic        issue_valid_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [31:0] rs1_i,
  input  wire logic [31:0] rs2_i,
  input  wire logic [31:0] rd_old_i,
  input  wire logic [31:0] pc_i,
  output logic             done_o,
  output logic             illegal_o,
  output logic             rd_write_o,
  output logic      [4:0]  rd_addr_o,
  output logic      [31:0] result_o,
  output logic             branch_valid_o,
  output logic             branch_taken_o,
  output logic      [31:0] next_pc_o
);

  // Instruction fields
  logic [6:0]  opcode;
  logic [2:0]  funct3;
  logic [6:0]  funct7;
  logic [4:0]  field_24_20;
  logic [1:0]  form_select_bits;
  logic [4:0]  shift_amount_immediate;
  logic [4:0]  unsigned_five_bit_immediate;
  logic [31:0] compare_immediate;
  logic [31:0] branch_offset;

  always_comb begin
    opcode                      = instr_i[6:0];
    funct3                      = instr_i[14:12];
    funct7                      = instr_i[31:25];
    field_24_20                 = instr_i[24:20];
    form_select_bits            = instr_i[31:30];
    shift_amount_immediate      = instr_i[29:25];
    unsigned_five_bit_immediate = instr_i[24:20];
    compare_immediate           = {{27{instr_i[24]}}, instr_i[24:20]};
    branch_offset               = {{19{instr_i[31]}}, instr_i[31], instr_i[7],
                                   instr_i[30:25], instr_i[11:8], 1'b0};
  end

  // Decode
  alu_op_type  op;
  logic        ours;
  logic        sr_sub;
  logic        sr_arith;
  logic        sr_round;
  logic        sr_regform;

  always_comb begin
    op         = OP_NONE;
    sr_sub     = 1'b0;
    sr_arith   = 1'b0;
    sr_round   = 1'b0;
    sr_regform = 1'b0;
    // Opcodes of this group are treated as foreign while the extension is off
    ours = custom_extension_enable_i &&
           (opcode == `OPC_GEN_ALU || opcode == `OPC_SHIFT_ADDSUB || opcode == `OPC_IMM_BRANCH);
    if (ours) begin
      op = OP_ILLEGAL;
      case (opcode)
        `OPC_GEN_ALU: begin
          if (funct3 == `F3_GEN_ALU) begin
            // Eight variants share funct7[6:3]; low three bits pick sub, round, unsigned
            if (funct7[6:3] == `F7_REGSHIFT_BASE) begin
              op         = OP_ADDSUB_SHIFT;
              sr_regform = 1'b1;
              sr_sub     = funct7[2];
              sr_arith   = ~funct7[0];
              sr_round   = funct7[1];
            end else begin
              case (funct7)
                `F7_ABS:        op = (field_24_20 == 5'h0) ? OP_ABS : OP_ILLEGAL;
                `F7_SLE:        op = OP_SLE_S;
                `F7_SLEU:       op = OP_SLE_U;
                `F7_MIN:        op = OP_MIN_S;
                `F7_MINU:       op = OP_MIN_U;
                `F7_MAX:        op = OP_MAX_S;
                `F7_MAXU:       op = OP_MAX_U;
                `F7_EXT_HALF_S: op = (field_24_20 == 5'h0) ? OP_EXT_HALF_S : OP_ILLEGAL;
                `F7_EXT_HALF_Z: op = (field_24_20 == 5'h0) ? OP_EXT_HALF_Z : OP_ILLEGAL;
                `F7_EXT_BYTE_S: op = (field_24_20 == 5'h0) ? OP_EXT_BYTE_S : OP_ILLEGAL;
                `F7_EXT_BYTE_Z: op = (field_24_20 == 5'h0) ? OP_EXT_BYTE_Z : OP_ILLEGAL;
                `F7_CLIP_IMM_S: op = OP_CLIP_IMM_S;
                `F7_CLIP_IMM_U: op = OP_CLIP_IMM_U;
                `F7_CLIP_REG_S: op = OP_CLIP_REG_S;
                `F7_CLIP_REG_U: op = OP_CLIP_REG_U;
                default:        op = OP_ILLEGAL;
              endcase
            end
          end
        end
        `OPC_SHIFT_ADDSUB: begin
          if (funct3 == `F3_ADD_SHIFT || funct3 == `F3_SUB_SHIFT) begin
            op       = OP_ADDSUB_SHIFT;
            sr_sub   = (funct3 == `F3_SUB_SHIFT);
            sr_arith = ~form_select_bits[0];
            sr_round = form_select_bits[1];
          end
        end
        `OPC_IMM_BRANCH: begin
          if (funct3 == `F3_BRANCH_EQ) begin
            op = OP_BRANCH_EQ;
          end else if (funct3 == `F3_BRANCH_NE) begin
            op = OP_BRANCH_NE;
          end
        end
        default: op = OP_ILLEGAL;
      endcase
    end
  end

  // Shared add/sub-shift datapath; register forms take rd as the left operand
  logic [31:0] sr_lhs;
  logic [31:0] sr_rhs;
  logic [4:0]  sr_shamt;
  logic [31:0] sr_result;

  always_comb begin
    sr_lhs   = sr_regform ? rd_old_i : rs1_i;
    sr_rhs   = sr_regform ? rs1_i : rs2_i;
    sr_shamt = sr_regform ? rs2_i[4:0] : shift_amount_immediate;
  end

  shift_round_unit #(
    .WIDTH (`XLEN)
  ) u_shift_round (
    .lhs_i      (sr_lhs),
    .rhs_i      (sr_rhs),
    .subtract_i (sr_sub),
    .arith_i    (sr_arith),
    .round_i    (sr_round),
    .shamt_i    (sr_shamt),
    .result_o   (sr_result)
  );

  // Compute result and branch decision
  logic [31:0] clip_upper;
  logic [31:0] value;
  logic        taken;
  logic        writes;

  always_comb begin
    // Signed lower bound is the bitwise inverse of the upper: -2^(k-1) and 2^(k-1)-1
    clip_upper = (unsigned_five_bit_immediate == 5'h0) ? 32'h0000_0000 :
                 32'((32'h1 << (unsigned_five_bit_immediate - 5'h1)) - 32'h1);
    value  = `REG_RESET_VALUE;
    taken  = 1'b0;
    writes = 1'b1;
    case (op)
      OP_ABS:        value = $signed(rs1_i) < 0 ? 32'(-rs1_i) : rs1_i;
      OP_SLE_S:      value = {31'h0, $signed(rs1_i) <= $signed(rs2_i)};
      OP_SLE_U:      value = {31'h0, rs1_i <= rs2_i};
      OP_MIN_S:      value = ($signed(rs1_i) < $signed(rs2_i)) ? rs1_i : rs2_i;
      OP_MIN_U:      value = (rs1_i < rs2_i) ? rs1_i : rs2_i;
      OP_MAX_S:      value = ($signed(rs1_i) < $signed(rs2_i)) ? rs2_i : rs1_i;
      OP_MAX_U:      value = (rs1_i < rs2_i) ? rs2_i : rs1_i;
      OP_EXT_HALF_S: value = {{16{rs1_i[15]}}, rs1_i[15:0]};
      OP_EXT_HALF_Z: value = {16'h0, rs1_i[15:0]};
      OP_EXT_BYTE_S: value = {{24{rs1_i[7]}}, rs1_i[7:0]};
      OP_EXT_BYTE_Z: value = {24'h0, rs1_i[7:0]};
      OP_CLIP_IMM_S: begin
        if ($signed(rs1_i) <= $signed(~clip_upper)) begin
          value = ~clip_upper;
        end else if ($signed(rs1_i) >= $signed(clip_upper)) begin
          value = clip_upper;
        end else begin
          value = rs1_i;
        end
      end
      OP_CLIP_IMM_U: begin
        if ($signed(rs1_i) <= 0) begin
          value = 32'h0000_0000;
        end else if ($signed(rs1_i) >= $signed(clip_upper)) begin
          value = clip_upper;
        end else begin
          value = rs1_i;
        end
      end
      OP_CLIP_REG_S: begin
        if ($signed(rs1_i) <= $signed(~rs2_i)) begin
          value = ~rs2_i;
        end else if ($signed(rs1_i) >= $signed(rs2_i)) begin
          value = rs2_i;
        end else begin
          value = rs1_i;
        end
      end
      OP_CLIP_REG_U: begin
        if ($signed(rs1_i) <= 0) begin
          value = 32'h0000_0000;
        end else if ($signed(rs1_i) >= $signed(rs2_i)) begin
          value = rs2_i;
        end else begin
          value = rs1_i;
        end
      end
      OP_ADDSUB_SHIFT: value = sr_result;
      OP_BRANCH_EQ: begin
        writes = 1'b0;
        taken  = (rs1_i == compare_immediate);
      end
      OP_BRANCH_NE: begin
        writes = 1'b0;
        taken  = (rs1_i != compare_immediate);
      end
      default: writes = 1'b0;
    endcase
  end

  // Output registers: one cycle from issue to answer
  logic        done_q,         done_d;
  logic        illegal_q,      illegal_d;
  logic        rd_write_q,     rd_write_d;
  logic [4:0]  rd_addr_q,      rd_addr_d;
  logic [31:0] result_q,       result_d;
  logic        branch_valid_q, branch_valid_d;
  logic        branch_taken_q, branch_taken_d;
  logic [31:0] next_pc_q,      next_pc_d;

  always_comb begin
    logic fire;
    fire           = issue_valid_i && ours;
    done_d         = fire;
    illegal_d      = fire && (op == OP_ILLEGAL);
    rd_write_d     = fire && writes;
    rd_addr_d      = fire ? instr_i[11:7] : 5'h0;
    result_d       = (fire && writes) ? value : `REG_RESET_VALUE;
    branch_valid_d = fire && (op == OP_BRANCH_EQ || op == OP_BRANCH_NE);
    branch_taken_d = branch_valid_d && taken;
    // Untaken branch falls through to the next sequential word
    next_pc_d      = branch_taken_d ? 32'(pc_i + branch_offset) : 32'(pc_i + `PC_STEP);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      done_q         <= 1'b0;
      illegal_q      <= 1'b0;
      rd_write_q     <= 1'b0;
      rd_addr_q      <= 5'h0;
      result_q       <= `REG_RESET_VALUE;
      branch_valid_q <= 1'b0;
      branch_taken_q <= 1'b0;
      next_pc_q      <= `REG_RESET_VALUE;
    end else begin
      done_q         <= done_d;
      illegal_q      <= illegal_d;
      rd_write_q     <= rd_write_d;
      rd_addr_q      <= rd_addr_d;
      result_q       <= result_d;
      branch_valid_q <= branch_valid_d;
      branch_taken_q <= branch_taken_d;
      next_pc_q      <= next_pc_d;
    end
  end

  always_comb begin
    done_o         = done_q;
    illegal_o      = illegal_q;
    rd_write_o     = rd_write_q;
    rd_addr_o      = rd_addr_q;
    result_o       = result_q;
    branch_valid_o = branch_valid_q;
    branch_taken_o = branch_taken_q;
    next_pc_o      = next_pc_q;
  end

endmodule
`default_nettype wire

// >>> tb/custom_alu_exec_props.sv
// Concurrent checks on the custom ALU block ports
`timescale 1ns/100ps
`default_nettype none
module custom_alu_exec_props (
  input wire logic        mclk_i,
  input wire logic        rst_i,
  input wire logic        custom_extension_enable_i,
  input wire logic        issue_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] rs1_i,
  input wire logic [31:0] rs2_i,
  input wire logic [31:0] rd_old_i,
  input wire logic [31:0] pc_i,
  input wire logic        done_o,
  input wire logic        illegal_o,
  input wire logic        rd_write_o,
  input wire logic [4:0]  rd_addr_o,
  input wire logic [31:0] result_o,
  input wire logic        branch_valid_o,
  input wire logic        branch_taken_o,
  input wire logic [31:0] next_pc_o
);
  logic        take;
  logic [31:0] imm;
  assign take = issue_valid_i && custom_extension_enable_i &&
                (instr_i[6:0] == 7'h2B || instr_i[6:0] == 7'h5B || instr_i[6:0] == 7'h0B);
  assign imm = {{27{instr_i[24]}}, instr_i[24:20]};

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_alu(logic [6:0] f);
    take && instr_i[6:0] == 7'h2B && instr_i[14:12] == 3'h3 && instr_i[31:25] == f;
  endsequence
  sequence s_br(logic [2:0] f3);
    take && instr_i[6:0] == 7'h0B && instr_i[14:12] == f3;
  endsequence

  property p_answer;
    done_o == $past(take);
  endproperty
  property p_abs;
    s_alu(7'h28) ##0 (instr_i[24:20] == 5'h00) |=>
      rd_write_o && result_o == ($past(rs1_i[31]) ? 32'h0 - $past(rs1_i) : $past(rs1_i));
  endproperty
  property p_reserved;
    s_alu(7'h28) ##0 (instr_i[24:20] != 5'h00) |=> illegal_o && !rd_write_o;
  endproperty
  property p_exths;
    s_alu(7'h30) ##0 (instr_i[24:20] == 5'h00) |=> result_o == {{16{$past(rs1_i[15])}}, $past(rs1_i[15:0])};
  endproperty
  property p_subnr;
    s_alu(7'h44) |=> result_o == 32'($signed($past(rd_old_i) - $past(rs1_i)) >>> $past(rs2_i[4:0]));
  endproperty
  property p_beq;
    s_br(3'h6) |=> branch_valid_o && branch_taken_o == ($past(rs1_i) == $past(imm));
  endproperty
  property p_bne;
    s_br(3'h7) |=> branch_valid_o && branch_taken_o == ($past(rs1_i) != $past(imm));
  endproperty
  property p_illegal;
    illegal_o |-> done_o && !rd_write_o && !branch_valid_o;
  endproperty

  a_answer: assert property (p_answer) else $error("done not one cycle after issue");
  a_abs: assert property (p_abs) else $error("abs result wrong");
  a_reserved: assert property (p_reserved) else $error("reserved field accepted");
  a_exths: assert property (p_exths) else $error("half sign extend wrong");
  a_subnr: assert property (p_subnr) else $error("signed subtract shift wrong");
  a_beq: assert property (p_beq) else $error("equal branch decision wrong");
  a_bne: assert property (p_bne) else $error("not equal branch decision wrong");
  a_illegal: assert property (p_illegal) else $error("illegal wrote a result");
endmodule

bind custom_alu_exec custom_alu_exec_props i_custom_alu_exec_props (
  .mclk_i(mclk_i), .rst_i(rst_i), .custom_extension_enable_i(custom_extension_enable_i),
  .issue_valid_i(issue_valid_i), .instr_i(instr_i), .rs1_i(rs1_i), .rs2_i(rs2_i), .rd_old_i(rd_old_i),
  .pc_i(pc_i), .done_o(done_o), .illegal_o(illegal_o), .rd_write_o(rd_write_o), .rd_addr_o(rd_addr_o),
  .result_o(result_o), .branch_valid_o(branch_valid_o), .branch_taken_o(branch_taken_o),
  .next_pc_o(next_pc_o));
`default_nettype wire

// >>> tb/regfile_model.sv
// Register file model standing in for the core pipeline
`timescale 1ns/100ps
`default_nettype none
module regfile_model (
  input  wire logic        mclk_i,
  input  wire logic [4:0]  rd_sel_i,
  input  wire logic        rd_write_i,
  input  wire logic [4:0]  rd_addr_i,
  input  wire logic [31:0] result_i,
  output logic      [31:0] rd_old_o
);
  logic [31:0] regs [32];
  assign rd_old_o = regs[rd_sel_i];
  // Write lands after the design has sampled the old value
  always @(posedge mclk_i) begin
    if (rd_write_i) begin
      regs[rd_addr_i] <= result_i;
    end
  end
  task automatic load(input logic [4:0] a, input logic [31:0] v);
    regs[a] = v;
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the custom ALU and immediate branch block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        en = 1'b1;
  logic        valid = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [31:0] rs1 = 32'h0;
  logic [31:0] rs2 = 32'h0;
  logic [31:0] pc = 32'h0;
  logic [31:0] rd_old, result, next_pc;
  logic [4:0]  rd_addr;
  logic        done, illegal, rd_write, br_valid, br_taken;
  int          n_mismatch = 0;
  int          n_compared = 0;

  always #2 mclk_i = ~mclk_i;

  regfile_model i_regfile_model (.mclk_i(mclk_i), .rd_sel_i(instr[11:7]), .rd_write_i(rd_write),
    .rd_addr_i(rd_addr), .result_i(result), .rd_old_o(rd_old));
  custom_alu_exec i_custom_alu_exec (.mclk_i(mclk_i), .rst_i(rst_i), .custom_extension_enable_i(en),
    .issue_valid_i(valid), .instr_i(instr), .rs1_i(rs1), .rs2_i(rs2), .rd_old_i(rd_old), .pc_i(pc),
    .done_o(done), .illegal_o(illegal), .rd_write_o(rd_write), .rd_addr_o(rd_addr), .result_o(result),
    .branch_valid_o(br_valid), .branch_taken_o(br_taken), .next_pc_o(next_pc));

  task automatic test_done();
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Valid stays high between calls so it is never set twice in one step
  task automatic run(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b, input logic [31:0] p);
    instr = ins;
    rs1 = a;
    rs2 = b;
    pc = p;
    valid = 1'b1;
    @(posedge mclk_i);
    #1;
  endtask

  function automatic logic [31:0] alux(input logic [6:0] f, input logic [31:0] a, input logic [31:0] b);
    case (f)
      7'h28: return a[31] ? -a : a;
      7'h29: return {31'h0, $signed(a) <= $signed(b)};
      7'h2A: return {31'h0, a <= b};
      7'h2B: return $signed(a) < $signed(b) ? a : b;
      7'h2C: return a < b ? a : b;
      7'h2D: return $signed(a) < $signed(b) ? b : a;
      7'h2E: return a < b ? b : a;
      7'h30: return {{16{a[15]}}, a[15:0]};
      7'h31: return {16'h0, a[15:0]};
      7'h32: return {{24{a[7]}}, a[7:0]};
      default: return {24'h0, a[7:0]};
    endcase
  endfunction

  // Mode bits: 0 unsigned, 1 rounding, 2 subtract; wraps at 32 bits
  function automatic logic [31:0] shx(input logic [2:0] m, input logic [31:0] a, input logic [31:0] b,
                                      input logic [4:0] n);
    logic [31:0] s;
    s = m[2] ? a - b : a + b;
    if (m[1] && n != 5'h00) s = s + (32'h1 << (n - 5'h01));
    if (m[0]) return s >> n;
    return $signed(s) >>> n;
  endfunction

  task automatic alu_chk(input logic [6:0] f, input logic [4:0] fld, input logic [31:0] a, input logic [31:0] b,
                         input logic [31:0] exp);
    run({f, fld, 5'h01, 3'h3, 5'h0A, 7'h2B}, a, b, 32'h0);
    chk({done, rd_write, illegal, rd_addr}, {3'b110, 5'h0A});
    chk(result, exp);
  endtask

  task automatic t_alu();
    logic [6:0]  fs [11] = '{7'h28, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h30, 7'h31, 7'h32, 7'h33};
    logic [31:0] a;
    for (int p = 0; p < 2; p++) begin
      a = (p == 1) ? 32'h0000_0005 : 32'hFFFF_8081;
      foreach (fs[i]) begin
        alu_chk(fs[i], (fs[i] == 7'h28 || fs[i] > 7'h2F) ? 5'h00 : 5'h05, a, 32'h5, alux(fs[i], a, 32'h5));
      end
    end
  endtask

  task automatic t_clip();
    alu_chk(7'h38, 5'h00, 32'h5, 32'h0, 32'h0);
    alu_chk(7'h38, 5'h00, 32'hFFFF_FFF9, 32'h0, 32'hFFFF_FFFF);
    alu_chk(7'h38, 5'h04, 32'h64, 32'h0, 32'h7);
    alu_chk(7'h38, 5'h04, 32'hFFFF_FF9C, 32'h0, 32'hFFFF_FFF8);
    alu_chk(7'h39, 5'h04, 32'hFFFF_FFFD, 32'h0, 32'h0);
    alu_chk(7'h3A, 5'h02, 32'hFFFF_FFEC, 32'hA, 32'hFFFF_FFF5);
    alu_chk(7'h3B, 5'h02, 32'h14, 32'hA, 32'hA);
  endtask

  task automatic t_shift();
    logic [4:0]  ns [3] = '{5'h00, 5'h01, 5'h04};
    logic [31:0] b;
    for (int k = 0; k < 16; k++) begin
      foreach (ns[j]) begin
        // Upper bits of source two set, so in the register forms only its low five may count
        b = 32'hFFFF_FFE0 | ns[j];
        i_regfile_model.load(5'h03, 32'h8000_0013);
        if (k[3]) begin
          run({4'h8, k[2:0], 5'h02, 5'h01, 3'h3, 5'h03, 7'h2B}, 32'h19, b, 32'h0);
          chk(result, shx(k[2:0], 32'h8000_0013, 32'h19, ns[j]));
        end else begin
          run({k[1:0], ns[j], 5'h02, 5'h01, 2'b01, k[2], 5'h03, 7'h5B}, 32'h19, b, 32'h0);
          chk(result, shx(k[2:0], 32'h19, b, ns[j]));
        end
      end
    end
  endtask

  task automatic br(input logic [2:0] f3, input logic [12:0] o, input logic [31:0] a, input logic tk);
    run({o[12], o[10:5], 5'h1D, 5'h01, f3, o[4:1], o[11], 7'h0B}, a, 32'h0, 32'h100);
    chk({br_valid, br_taken, rd_write}, {1'b1, tk, 1'b0});
    chk(next_pc, tk ? 32'h100 + {{19{o[12]}}, o} : 32'h104);
  endtask

  task automatic t_branch();
    br(3'h6, 13'h1FF0, 32'hFFFF_FFFD, 1'b1);
    br(3'h6, 13'h1FF0, 32'h1D, 1'b0);
    br(3'h7, 13'h0802, 32'h1D, 1'b1);
    br(3'h7, 13'h0802, 32'hFFFF_FFFD, 1'b0);
  endtask

  task automatic t_illegal();
    i_regfile_model.load(5'h07, 32'hA5A5_0001);
    run({7'h2F, 5'h02, 5'h01, 3'h3, 5'h07, 7'h2B}, 32'h1, 32'h1, 32'h0);
    chk({done, illegal, rd_write}, 3'b110);
    run({7'h28, 5'h03, 5'h01, 3'h3, 5'h07, 7'h2B}, 32'h1, 32'h1, 32'h0);
    chk({done, illegal, rd_write}, 3'b110);
    en = 1'b0;
    run({7'h28, 5'h00, 5'h01, 3'h3, 5'h07, 7'h2B}, 32'h1, 32'h1, 32'h0);
    chk({done, rd_write}, 2'b00);
    chk(i_regfile_model.regs[7], 32'hA5A5_0001);
    en = 1'b1;
  endtask

  initial begin
    repeat (6) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    @(posedge mclk_i);
    #1;
    chk({done, illegal, rd_write, br_valid}, 4'h0);
    chk(result, 32'h0);
    t_alu();
    t_clip();
    t_shift();
    t_branch();
    t_illegal();
    test_done();
  end

  // Cuts a hang short at 25000 cycles, far beyond the 91 a passing run needs
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
endmodule
`default_nettype wire
